/* File: hw/snm_host_ctrl.sv */
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
// Function
// [RULE1] receiver pulls data low on the ninth clock to acknowledge each byte
// [RULE2] transmitter releases data on the ninth clock for the acknowledge
// [RULE3] stop before an acknowledge makes the memory abort to standby
// [RULE4] after a not-acknowledge the bus is released; master sends stop
// [RULE5] after start, send type code, three select bits, direction bit
// [RULE6] memory compares upper four bits against its type code
// [RULE7] memory matches select bits 2,1,0 against its strap pins
// [RULE8] eighth address-word bit: zero write, one read
// [RULE9] memory ignores a mismatched address word without acknowledge
// [RULE10] two memory address bytes follow, high first, each acknowledged
// [RULE11] master always drives clock; data driver follows direction bit
// [RULE12] in writes, next byte goes only after the acknowledge is seen
// [RULE13] in reads, memory shifts eight bits then waits for master's bit
// [RULE14] memory never withholds acknowledges for internal writes
// [RULE15] write-inhibit pin high blocks all writes; reads always allowed
// [RULE16] top three bits of the high address byte are sent as zero
// [RULE17] byte write: start, word, high, low, one data byte, stop
// [RULE18] extra write bytes go to following addresses, wrapping to zero
// [RULE19] memory commits each byte right after its acknowledge
// [RULE20] read without address phase returns the next location
// [RULE21] memory current address is undefined after power-up
// [RULE22] current read: start, word with one, one byte, not-ack, stop
// [RULE23] data sampled on clock rise, changed while clock is low
// [RULE24] start is data falling while clock is high
// [RULE25] stop is data rising while clock is high; memory goes standby
// [RULE26] memory keeps a thirteen-bit address counter wrapping at 8191
// [RULE27] inhibited writes still acknowledge and advance the address
module snm_host_ctrl (
  input  wire logic       core_clk,   // core clock, 40 MHz
  input  wire logic       arst_n,     // async reset, active low
  input  wire logic [7:0] reg_addr,   // register byte address
  input  wire logic [7:0] reg_wdata,  // register write data
  input  wire logic       reg_wr,     // write strobe
  input  wire logic       reg_rd,     // read strobe
  output logic      [7:0] reg_rdata,  // read data, cycle after strobe
  input  wire logic       scl_i,      // serial clock pin level
  output logic            scl_o,      // serial clock drive value
  output logic            scl_oe,     // high while pulling clock low
  input  wire logic       sda_i,      // serial data pin level
  output logic            sda_o,      // serial data drive value
  output logic            sda_oe,     // high while pulling data low
  output logic            wr_inhibit  // write-inhibit pin drive
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  snm_pkg::snm_state_t st_reg;

  logic [1:0]                   q_reg;        // quarter within a bit
  logic [3:0]                   bit_reg;      // bit within a byte, 8 = ack slot
  logic [7:0]                   shift_reg;
  logic                         ack_reg;      // sampled acknowledge level
  logic [snm_pkg::LEN_W-1:0]    idx_reg;      // data bytes loaded into the shifter
  logic                         busy_reg;
  logic                         nack_reg;
  logic                         done_reg;
  logic                         rxv_reg;
  logic [7:0]                   rxbyte_reg;
  logic                         abort_reg;
  logic                         op_rd_reg;
  logic [3:0]                   type_reg;
  logic [2:0]                   sel_reg;
  logic [snm_pkg::MADDR_W-1:0]  maddr_reg;
  logic [snm_pkg::LEN_W-1:0]    len_reg;
  logic [7:0]                   buf_mem [snm_pkg::BUF_DEPTH];
  logic [1:0]                   pins_s;
  logic                         scl_s;
  logic                         sda_s;
  logic                         qtick;
  logic                         go;
  logic                         abort_req;
  logic                         advance;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // zero length means one byte
  function automatic logic [snm_pkg::LEN_W-1:0] len_eff(
    input logic [snm_pkg::LEN_W-1:0] len
  );
    len_eff = (len == '0) ? snm_pkg::LEN_W'(1) : len;
  endfunction

  function automatic logic [snm_pkg::BUF_AW-1:0] buf_index(input logic [7:0] addr);
    buf_index = addr[snm_pkg::BUF_AW+1:2];
  endfunction

  function automatic logic is_buf(input logic [7:0] addr);
    is_buf = (addr >= snm_pkg::OFS_BUF) && (addr <= snm_pkg::OFS_BUF_END) &&
             (addr[1:0] == 2'b00);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and quarter-bit divider
  // ----------------------------------------------------------------
  snm_sync2 #(.W(2)) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in ({scl_i, sda_i}),
    .sync_out (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  snm_tick_div u_div (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run      (busy_reg),
    .qtick    (qtick)
  );

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // launch only from idle; a go while busy is dropped
  assign go = reg_wr && (reg_addr == snm_pkg::OFS_CTRL) &&
              reg_wdata[snm_pkg::CTRL_GO_BIT] && (st_reg == snm_pkg::SNM_IDLE);
  assign abort_req = reg_wr && (reg_addr == snm_pkg::OFS_CTRL) &&
                     reg_wdata[snm_pkg::CTRL_ABORT_BIT] && busy_reg;
  // the step after the clock release waits for the pin to read high;
  // a stall at the release step itself would hold the clock low forever
  assign advance = qtick && (st_reg != snm_pkg::SNM_IDLE) &&
                   !((q_reg == 2'd2) && !scl_s);

  // ----------------------------------------------------------------
  // software configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_rd_reg  <= 1'b0;
      wr_inhibit <= 1'b0;
      type_reg   <= snm_pkg::TYPE_RST;
      sel_reg    <= snm_pkg::SEL_RST;
      maddr_reg  <= '0;
      len_reg    <= snm_pkg::LEN_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        snm_pkg::OFS_CTRL: begin
          if (!busy_reg) begin
            op_rd_reg <= reg_wdata[snm_pkg::CTRL_OP_BIT];
          end
          wr_inhibit <= reg_wdata[snm_pkg::CTRL_INH_BIT];  // [RULE15]
        end
        snm_pkg::OFS_DEVSEL: begin
          sel_reg  <= reg_wdata[2:0];
          type_reg <= reg_wdata[7:4];
        end
        snm_pkg::OFS_MADDR: begin
          maddr_reg <= {reg_wdata[4:0], maddr_reg[7:0]};
        end
        snm_pkg::OFS_LEN: begin
          len_reg <= reg_wdata[snm_pkg::LEN_W-1:0];
        end
        default: begin
          // low address byte; buffer offsets are stored by the buffer block, other offsets store nothing
          if (reg_addr == snm_pkg::OFS_MADDR_LO) begin
            maddr_reg <= {maddr_reg[12:8], reg_wdata};
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // write data buffer, no reset on the array
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reg_wr && is_buf(reg_addr)) begin
      buf_mem[buf_index(reg_addr)] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // read-back, data valid the cycle after the strobe only
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        snm_pkg::OFS_CTRL:   reg_rdata <= {5'h00, wr_inhibit, op_rd_reg, 1'b0};
        snm_pkg::OFS_DEVSEL: reg_rdata <= {type_reg, 1'b0, sel_reg};
        snm_pkg::OFS_MADDR:  reg_rdata <= {3'h0, maddr_reg[12:8]};
        snm_pkg::OFS_LEN:    reg_rdata <= {3'h0, len_reg};
        snm_pkg::OFS_STATUS: reg_rdata <= {4'h0, rxv_reg, done_reg, nack_reg, busy_reg};
        snm_pkg::OFS_RDATA:  reg_rdata <= rxbyte_reg;
        default: begin
          if (reg_addr == snm_pkg::OFS_MADDR_LO) begin
            reg_rdata <= maddr_reg[7:0];
          end else if (is_buf(reg_addr)) begin
            reg_rdata <= buf_mem[buf_index(reg_addr)];
          end else begin
            reg_rdata <= '0;  // unmapped reads as zero
          end
        end
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // status flags; go sets busy and clears abort, only from idle; other sets only happen while busy
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg  <= 1'b0;
      abort_reg <= 1'b0;
    end else if (go) begin
      busy_reg  <= 1'b1;
      abort_reg <= 1'b0;
    end else begin
      if (abort_req) begin
        abort_reg <= 1'b1;
      end
      if (advance && (st_reg == snm_pkg::SNM_STOP) && (q_reg == 2'd3)) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // open-drain drive values are always low; only the enables move
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // bit engine: q0 set data (clock low), q1 release clock,
  // q2 sample (clock high), q3 pull clock low
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg     <= snm_pkg::SNM_IDLE;
      q_reg      <= 2'd0;
      bit_reg    <= '0;
      shift_reg  <= '0;
      ack_reg    <= 1'b1;
      idx_reg    <= '0;
      scl_oe     <= 1'b0;
      sda_oe     <= 1'b0;
      nack_reg   <= 1'b0;
      done_reg   <= 1'b0;
      rxv_reg    <= 1'b0;
      rxbyte_reg <= '0;
    end else if (go) begin
      st_reg   <= snm_pkg::SNM_START;
      q_reg    <= 2'd0;
      nack_reg <= 1'b0;
      done_reg <= 1'b0;
      rxv_reg  <= 1'b0;
    end else if (advance) begin
      q_reg <= q_reg + 2'd1;
      case (st_reg)
        snm_pkg::SNM_START: begin
          case (q_reg)
            2'd0: begin
              sda_oe <= 1'b0;
              scl_oe <= 1'b0;
            end
            2'd2: sda_oe <= 1'b1;  // [RULE24]
            2'd3: begin
              scl_oe    <= 1'b1;
              st_reg    <= snm_pkg::SNM_DEVW;
              bit_reg   <= '0;
              shift_reg <= {type_reg, sel_reg, op_rd_reg};  // [RULE5] [RULE7] [RULE8]
            end
            default: ;
          endcase
        end
        snm_pkg::SNM_STOP: begin
          case (q_reg)
            2'd0: sda_oe <= 1'b1;  // data low while clock low
            2'd1: scl_oe <= 1'b0;
            2'd2: sda_oe <= 1'b0;  // [RULE25]
            2'd3: begin
              st_reg   <= snm_pkg::SNM_IDLE;
              done_reg <= 1'b1;
            end
            default: ;
          endcase
        end
        snm_pkg::SNM_RDAT: begin
          // memory drives the data bits; the master answers not-ack by releasing
          case (q_reg)
            2'd0: sda_oe <= 1'b0;  // [RULE11] [RULE22]
            2'd1: scl_oe <= 1'b0;
            2'd2: begin
              if (bit_reg != snm_pkg::ACK_BIT_IDX) begin
                shift_reg <= {shift_reg[6:0], sda_s};  // [RULE13] [RULE23]
              end
            end
            2'd3: begin
              scl_oe <= 1'b1;
              if (bit_reg == snm_pkg::ACK_BIT_IDX) begin
                rxbyte_reg <= shift_reg;
                rxv_reg    <= 1'b1;
                st_reg     <= snm_pkg::SNM_STOP;  // [RULE4]
              end else begin
                bit_reg <= bit_reg + 4'd1;
              end
            end
            default: ;
          endcase
        end
        snm_pkg::SNM_IDLE: ;
        default: begin
          // transmit states: address word, address bytes, data bytes
          case (q_reg)
            2'd0: begin
              if (bit_reg == snm_pkg::ACK_BIT_IDX) begin
                sda_oe <= 1'b0;  // [RULE2]
              end else begin
                sda_oe <= ~shift_reg[7];  // [RULE23]
              end
            end
            2'd1: scl_oe <= 1'b0;
            2'd2: begin
              if (bit_reg == snm_pkg::ACK_BIT_IDX) begin
                ack_reg <= sda_s;  // [RULE1]
              end
            end
            2'd3: begin
              scl_oe <= 1'b1;
              if (bit_reg != snm_pkg::ACK_BIT_IDX) begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_reg   <= bit_reg + 4'd1;
              end else begin
                bit_reg <= '0;
                if (ack_reg) begin
                  nack_reg <= 1'b1;  // covers a mismatched address word
                  st_reg   <= snm_pkg::SNM_STOP;  // [RULE4] [RULE9]
                end else if (abort_reg) begin
                  st_reg <= snm_pkg::SNM_STOP;
                end else begin
                  // next byte only after an acknowledge was seen
                  case (st_reg)  // [RULE12]
                    snm_pkg::SNM_DEVW: begin
                      if (op_rd_reg) begin
                        st_reg <= snm_pkg::SNM_RDAT;  // [RULE20]
                      end else begin
                        st_reg    <= snm_pkg::SNM_AHI;  // [RULE10]
                        shift_reg <= {snm_pkg::ADDR_HI_PAD, maddr_reg[12:8]};  // [RULE16]
                      end
                    end
                    snm_pkg::SNM_AHI: begin
                      st_reg    <= snm_pkg::SNM_ALO;
                      shift_reg <= maddr_reg[7:0];
                    end
                    snm_pkg::SNM_ALO: begin
                      st_reg    <= snm_pkg::SNM_WDAT;  // [RULE17]
                      shift_reg <= buf_mem[0];
                      idx_reg   <= snm_pkg::LEN_W'(1);
                    end
                    default: begin
                      if (idx_reg == len_eff(len_reg)) begin
                        st_reg <= snm_pkg::SNM_STOP;
                      end else begin
                        // memory places these at the following addresses
                        shift_reg <= buf_mem[idx_reg[snm_pkg::BUF_AW-1:0]];  // [RULE18]
                        idx_reg   <= idx_reg + 1'b1;
                      end
                    end
                  endcase
                end
              end
            end
            default: ;
          endcase
        end
      endcase
    end
  end

endmodule

/* File: hw/snm_pkg.sv */
package snm_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;    // core_clk, 40 MHz
  localparam int unsigned SCL_PERIOD_NS = 2500;  // serial clock, 400 kHz
  // four quarter phases per serial bit; a longest time, so it rounds down
  localparam int unsigned QTR_CYCLES    = (SCL_PERIOD_NS / 4) / CLK_PERIOD_NS;
  localparam int unsigned QTR_W         = 8;

  // ----------------------------------------------------------------
  // software register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DEVSEL = 8'h04;
  localparam logic [7:0] OFS_MADDR  = 8'h08;
  localparam logic [7:0] OFS_MADDR_LO = 8'h28;  // low memory address byte
  localparam logic [7:0] OFS_LEN    = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RDATA  = 8'h14;
  localparam logic [7:0] OFS_BUF    = 8'h40;  // 16 words, one data byte each
  localparam logic [7:0] OFS_BUF_END = 8'h7c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_GO_BIT    = 0;  // write 1 to launch
  localparam int unsigned CTRL_OP_BIT    = 1;  // 0 write, 1 current read
  localparam int unsigned CTRL_INH_BIT   = 2;  // write-inhibit pin level
  localparam int unsigned CTRL_ABORT_BIT = 3;  // write 1 to stop early
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_NACK_BIT    = 1;
  localparam int unsigned ST_DONE_BIT    = 2;
  localparam int unsigned ST_RXV_BIT     = 3;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned MADDR_W     = 13;  // meaningful memory address bits
  localparam int unsigned BUF_DEPTH   = 16;
  localparam int unsigned BUF_AW      = 4;
  localparam int unsigned LEN_W       = 5;
  localparam logic [3:0]  TYPE_RST    = 4'h5;  // arbitrary, software sets the real code
  localparam logic [2:0]  SEL_RST     = 3'h0;
  localparam logic [4:0]  LEN_RST     = 5'h01;
  localparam logic [2:0]  ADDR_HI_PAD = 3'h0;  // top bits of the high address byte
  localparam logic [3:0]  ACK_BIT_IDX = 4'h8;  // ninth bit of each byte

  // ----------------------------------------------------------------
  // transaction states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SNM_IDLE,
    SNM_START,
    SNM_DEVW,
    SNM_AHI,
    SNM_ALO,
    SNM_WDAT,
    SNM_RDAT,
    SNM_STOP
  } snm_state_t;

endpackage

/* File: hw/snm_sync2.sv */
`timescale 1ns/100ps
// two-flop synchroniser for pin levels
module snm_sync2 #(
  parameter int unsigned W = 2
) (
  input  wire logic         core_clk,  // core clock
  input  wire logic         arst_n,    // async reset, active low
  input  wire logic [W-1:0] async_in,  // raw pin levels
  output logic      [W-1:0] sync_out   // levels safe to use
);

  logic [W-1:0] meta_reg;

  // ----------------------------------------------------------------
  // two stages; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '1;  // idle bus reads high
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

/* File: hw/snm_tick_div.sv */
`timescale 1ns/100ps
// quarter-bit enable pulse generator
module snm_tick_div (
  input  wire logic core_clk,  // core clock
  input  wire logic arst_n,    // async reset, active low
  input  wire logic run,       // count only while a transfer runs
  output logic      qtick      // one-cycle pulse per quarter bit
);

  localparam logic [snm_pkg::QTR_W-1:0] QTR_LAST =
    snm_pkg::QTR_W'(snm_pkg::QTR_CYCLES - 1);

  logic [snm_pkg::QTR_W-1:0] cnt_reg;

  // ----------------------------------------------------------------
  // divider; restarts from zero when idle so every frame is aligned
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      qtick   <= 1'b0;
    end else if (!run) begin
      cnt_reg <= '0;
      qtick   <= 1'b0;
    end else if (cnt_reg == QTR_LAST) begin
      cnt_reg <= '0;
      qtick   <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      qtick   <= 1'b0;
    end
  end

endmodule

/* File: verif/snm_host_props.sv */
`timescale 1ns/100ps
// pin checks beside the host controller
module snm_host_props (
  input wire logic       core_clk,  // clock
  input wire logic       arst_n,    // reset
  input wire logic [7:0] reg_addr,  // address
  input wire logic       reg_wr,    // write
  input wire logic       reg_rd,    // read
  input wire logic [7:0] reg_rdata, // read data
  input wire logic       scl_o,     // clk value
  input wire logic       scl_oe,    // clk pull
  input wire logic       sda_o,     // data value
  input wire logic       sda_oe,    // data pull
  input wire logic       wr_inhibit // inhibit pin
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [3:0] bitn;
  // bit number in the byte, bumped at each clock release
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) bitn <= 4'h0;
    else if ($rose(sda_oe) && !scl_oe) bitn <= 4'h0;
    else if ($fell(scl_oe)) bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
  end
  od_pins_a: assert property (!scl_o && !sda_o)
    else $error("drive value not low");
  start_form_a: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:30] scl_oe)
    else $error("no clock after start");
  stop_form_a: assert property ($fell(sda_oe) && !scl_oe |=> !scl_oe [*8])
    else $error("clock pulled after stop");
  // the falling edge itself still shows the previous bit
  ack_free_a: assert property (bitn == 4'h9 && !scl_oe && !$fell(scl_oe) |-> !sda_oe)
    else $error("data held in ack slot");
  low_hold_a: assert property ($rose(scl_oe) |=> scl_oe [*8])
    else $error("short clock low");
  high_hold_a: assert property ($fell(scl_oe) |=> !scl_oe [*8])
    else $error("short clock high");
  inh_src_a: assert property ($changed(wr_inhibit) |-> $past(reg_wr) && $past(reg_addr) == 8'h00)
    else $error("inhibit moved alone");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  c_start: cover property ($rose(sda_oe) && !scl_oe);
  c_stop: cover property ($fell(sda_oe) && !scl_oe);
  c_ack: cover property (bitn == 4'h9 && !scl_oe);
endmodule
bind snm_host_ctrl snm_host_props i_props (.core_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd,
  .reg_rdata, .scl_o, .scl_oe, .sda_o, .sda_oe, .wr_inhibit);

/* File: verif/snm_mem_model.sv */
`timescale 1ns/100ps
// behavioural two-wire memory on the far side
module snm_mem_model #(
  parameter logic [3:0] TYPE_CODE = 4'h6 // arbitrary value
) (
  input  wire logic       scl,        // clock wire
  input  wire logic       sda,        // data wire
  input  wire logic       wr_inhibit, // inhibit pin
  input  wire logic [2:0] sel_pins,   // select straps
  output logic            pull        // pulls data low
);
  logic [7:0]  mem [0:8191];
  logic [12:0] addr; // unknown until set
  logic [7:0]  sh;
  int          bits = 0;
  int          ph = 0; // 0 standby 1 word 2 hi 3 lo 4 write 5 read
  initial pull = 1'b0;
  // start and stop, seen while the clock is high
  always @(negedge sda) if (scl) begin
    ph = 1;
    bits = 0;
  end
  always @(posedge sda) if (scl) begin
    ph = 0;
    pull <= 1'b0;
  end
  // sample on the rise; in a read the rotating shifter refills itself
  always @(posedge scl) if (ph != 0) begin
    if (bits < 8) sh = {sh[6:0], sda};
    else if (ph == 5 && sda) ph = 0;
    bits = bits + 1;
  end
  // drive on the fall: acknowledge, read data, or release
  always @(negedge scl) if (ph != 0) begin
    if (bits == 9) begin
      bits = 0;
      if (ph == 5) begin
        sh = mem[addr];
        addr = addr + 13'h1;
      end
    end
    if (bits == 8 && ph != 5) begin
      case (ph)
        1: ph = (sh[7:4] == TYPE_CODE && sh[3:1] == sel_pins) ? (sh[0] ? 5 : 2) : 0;
        2: {ph, addr[12:8]} = {32'd3, sh[4:0]};
        3: {ph, addr[7:0]} = {32'd4, sh};
        default: begin
          if (!wr_inhibit) mem[addr] = sh;
          addr = addr + 13'h1;
        end
      endcase
      pull <= (ph != 0);
    end else pull <= (ph == 5) && (bits < 8) && !sh[7];
  end
endmodule

/* File: verif/test_snm_host_ctrl.sv */
`timescale 1ns/100ps
// directed bench: host controller against a behavioural memory
module test_snm_host_ctrl;
  localparam logic [2:0] PINS = 3'h5;
  localparam logic [3:0] TYPE = 4'h6; // arbitrary value
  logic       core_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata, st, rv;
  logic       scl_o, scl_oe, sda_o, sda_oe, wr_inhibit, pull;
  int         num_errors = 0;
  int         cmp_count = 0;
  wire logic  scl_w = !scl_oe;           // only the host pulls the clock
  wire logic  sda_w = !(sda_oe || pull); // pulled up unless held low
  snm_host_ctrl i_dut (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .scl_i(scl_w), .scl_o, .scl_oe, .sda_i(sda_w), .sda_o, .sda_oe, .wr_inhibit);
  snm_mem_model #(.TYPE_CODE(TYPE)) i_mem (.scl(scl_w), .sda(sda_w), .wr_inhibit,
    .sel_pins(PINS), .pull);
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // launch, then poll until done; a lost transfer runs into the watchdog
  task automatic run(input logic [7:0] ctrl);
    wr(snm_pkg::OFS_CTRL, ctrl);
    do rd(snm_pkg::OFS_STATUS);
    while (rv[snm_pkg::ST_DONE_BIT] !== 1'b1);
    st = rv;
  endtask
  // page write from 1ffe runs over the top of the array to zero
  task automatic t_page_wrap();
    logic [7:0] v [3] = '{8'h33, 8'h11, 8'h22};
    wr(8'h08, 8'h1f);
    wr(8'h28, 8'hfe);
    wr(snm_pkg::OFS_LEN, 8'h03);
    foreach (v[i]) wr(snm_pkg::OFS_BUF + 8'(4 * i), v[i]);
    run(8'h01);
    chk("stat", 8'h04, st & 8'h07);
    chk("m1ffe", 8'h33, i_mem.mem[13'h1ffe]);
    chk("m1fff", 8'h11, i_mem.mem[13'h1fff]);
    chk("m0000", 8'h22, i_mem.mem[13'h0000]);
  endtask
  // inhibited byte write is acknowledged and leaves the array alone
  task automatic t_inhibit();
    wr(snm_pkg::OFS_LEN, 8'h01);
    wr(snm_pkg::OFS_BUF, 8'h99);
    run(8'h05);
    chk("pin", 8'h01, {7'h0, wr_inhibit});
    chk("stat", 8'h04, st & 8'h07);
    chk("m1ffe", 8'h33, i_mem.mem[13'h1ffe]);
  endtask
  // two current reads, still inhibited, walk on and wrap
  task automatic t_cur_read();
    logic [7:0] e [2] = '{8'h11, 8'h22};
    foreach (e[i]) begin
      run(8'h07);
      chk("stat", 8'h0c, st & 8'h0f);
      rd(snm_pkg::OFS_RDATA);
      chk("rdata", e[i], rv);
    end
  endtask
  // abort taken while busy ends the frame after the address word
  task automatic t_abort();
    wr(snm_pkg::OFS_CTRL, 8'h01);
    run(8'h08);
    chk("stat", 8'h04, st & 8'h07);
    chk("m1ffe", 8'h33, i_mem.mem[13'h1ffe]);
  endtask
  // wrong select or type code gets no acknowledge, bus left idle
  task automatic t_no_match();
    logic [7:0] b [2] = '{{TYPE, 1'b0, ~PINS}, {~TYPE, 1'b0, PINS}};
    foreach (b[i]) begin
      wr(snm_pkg::OFS_DEVSEL, b[i]);
      run(i == 0 ? 8'h01 : 8'h03);
      chk("stat", 8'h06, st & 8'h07);
      chk("idle", 8'h03, {6'h0, scl_w, sda_w});
      chk("m1fff", 8'h11, i_mem.mem[13'h1fff]);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    wr(snm_pkg::OFS_DEVSEL, {TYPE, 1'b0, PINS});
    t_page_wrap();
    t_inhibit();
    t_cur_read();
    t_abort();
    t_no_match();
    final_report();
  end
  // the whole run needs about 17k cycles
  initial begin
    #1_000_000;
    num_errors++;
    final_report();
  end
endmodule
